// >>> dv/testbench.sv
/*
 * Self-checking bench for the interrupt enable and identification block.
 * Assumes the register port strobes answer one cycle after a read.
 */
`default_nettype none

module testbench
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] STOP = 8'h5a;  // Second stop character.

    logic       sys_clk, reset_n, reg_wr, reg_rd, reg_rvalid;
    reg_sel_t   reg_sel;
    logic [7:0] reg_wdata, reg_rdata, rx_char, flow_threshold;
    uart_src_t  src;
    logic       fifo_enable, rx_char_valid, rts_force_active, cts_pin_high;
    logic [6:0] rx_level;
    logic       irq_n, tx_halt, rts_pin_high, sleep_enable, enhanced_we;
    logic [3:0] sw_flow_mode;
    logic [5:0] level_cmd;
    logic [2:0] pulse_cmd;
    int         fails, samples_checked, i;
    logic [5:0] codes [6] = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h30};
    int         lv [4] = '{8, 6, 4, 7};

    uart_event_model uart_event_model_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .level_cmd(level_cmd), .pulse_cmd(pulse_cmd),
        .src(src));

    uart_irq_enable_ident uart_irq_enable_ident_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .src(src), .fifo_enable(fifo_enable),
        .rx_level(rx_level), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .second_stop_char(STOP),
        .flow_threshold(flow_threshold),
        .rts_force_active(rts_force_active), .cts_pin_high(cts_pin_high),
        .irq_n(irq_n), .tx_halt(tx_halt), .rts_pin_high(rts_pin_high),
        .sleep_enable(sleep_enable), .enhanced_we(enhanced_we),
        .sw_flow_mode(sw_flow_mode));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Compares one byte and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One write strobe; the effect shows after the strobe's edge.
    task automatic wr(input reg_sel_t s, input logic [7:0] d);
        @(negedge sys_clk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    // One read strobe; the answer stands for the single following cycle.
    task automatic rd(input reg_sel_t s, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_sel = s;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask

    // Waits a bounded time for the request line to reach a level.
    task automatic wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 8 && irq_n !== lvl; k++)
            @(negedge sys_clk);
        if (irq_n !== lvl) begin
            fails++;
            $display("ERROR %0t: request line stuck", $time);
            print_verdict();
        end else begin
            check({7'h00, irq_n}, {7'h00, lvl});
        end
    endtask

    // Expected identification byte; the top bits mirror our FIFO enable.
    function automatic logic [7:0] id(input logic [5:0] c);
        return {fifo_enable, fifo_enable, c};
    endfunction

    // Main sequence.
    initial begin
        {reset_n, reg_wr, reg_rd, fifo_enable, rx_char_valid} = 5'h00;
        {rts_force_active, cts_pin_high, pulse_cmd} = 5'h00;
        reg_sel = SEL_NONE;
        {reg_wdata, rx_char, flow_threshold} = 24'h000000;
        rx_level = 7'h00;
        level_cmd = 6'h00;
        {fails, samples_checked} = 64'h0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        rd(SEL_ENABLE, 8'h00);
        rd(SEL_ENHANCED, 8'h00);
        rd(SEL_IDENT, 8'h01);
        // Upper enable bits stay protected until the write enable is set.
        wr(SEL_ENABLE, 8'hff);
        rd(SEL_ENABLE, 8'h0f);
        wr(SEL_IDENT, 8'h55);
        rd(SEL_IDENT, 8'h01);
        rd(SEL_NONE, 8'h00);
        wr(SEL_ENHANCED, 8'h1a);
        check({4'h0, sw_flow_mode}, 8'h0a);
        check({7'h00, enhanced_we}, 8'h01);
        wr(SEL_ENABLE, 8'hff);
        rd(SEL_ENABLE, 8'hff);
        check({7'h00, sleep_enable}, 8'h01);
        // All levels at once; each drop must expose the next priority.
        fifo_enable = 1'b1;
        level_cmd = 6'h3f;
        wait_irq(1'b0);
        for (i = 0; i < 6; i++) begin
            rd(SEL_IDENT, id(codes[i]));
            level_cmd[5-i] = 1'b0;
            settle(3);
        end
        // Event sources are cleared by the read that reports them.
        for (i = 0; i < 3; i++) begin
            pulse_cmd = 3'b100 >> i;
            settle(3);
            rd(SEL_IDENT, id(i == 0 ? 6'h10 : 6'h20));
            rd(SEL_IDENT, id(6'h01));
            pulse_cmd = 3'h0;
        end
        wait_irq(1'b1);
        // A disabled source must not pend, an enabled one must.
        wr(SEL_ENABLE, 8'hfb);
        level_cmd = 6'h20;
        settle(3);
        check({7'h00, irq_n}, 8'h01);
        wr(SEL_ENABLE, 8'hff);
        wait_irq(1'b0);
        rd(SEL_IDENT, id(6'h06));
        // Re-enabling transmit while already below threshold stays quiet.
        level_cmd = 6'h04;
        settle(3);
        rd(SEL_IDENT, id(6'h02));
        wr(SEL_ENABLE, 8'hfd);
        wr(SEL_ENABLE, 8'hff);
        settle(3);
        rd(SEL_IDENT, id(6'h01));
        check({7'h00, irq_n}, 8'h01);
        level_cmd = 6'h00;
        // Only a matching character counts as special.
        wr(SEL_ENHANCED, 8'h30);
        for (i = 0; i < 2; i++) begin
            rx_char = (i == 0) ? (STOP ^ 8'h01) : STOP;
            rx_char_valid = 1'b1;
            settle(1);
            rx_char_valid = 1'b0;
            settle(2);
            rd(SEL_IDENT, id(i == 0 ? 6'h01 : 6'h10));
        end
        // Hardware flow control; halt at 8 characters, resume at 4.
        wr(SEL_ENHANCED, 8'hd0);
        cts_pin_high = 1'b1;
        flow_threshold = 8'h12;
        settle(2);
        check({7'h00, tx_halt}, 8'h01);
        for (i = 0; i < 4; i++) begin
            rx_level = 7'(lv[i]);
            settle(2);
            check({7'h00, rts_pin_high}, (i < 2) ? 8'h01 : 8'h00);
        end
        // A low CTS pin lets the transmitter run again.
        cts_pin_high = 1'b0;
        settle(2);
        check({7'h00, tx_halt}, 8'h00);
        cts_pin_high = 1'b1;
        // With both flow controls off the pins follow the plain controls.
        wr(SEL_ENHANCED, 8'h10);
        rts_force_active = 1'b1;
        settle(2);
        check({7'h00, tx_halt}, 8'h00);
        check({7'h00, rts_pin_high}, 8'h00);
        rts_force_active = 1'b0;
        settle(2);
        check({7'h00, rts_pin_high}, 8'h01);
        print_verdict();
    end

endmodule // testbench

`default_nettype wire

// >>> dv/uart_event_model.sv
/*
 * Behavioural model of the UART core that feeds the event sources.
 * Assumes the bench changes its commands just after a falling edge.
 */
`default_nettype none

module uart_event_model
    import uart_irq_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [5:0] level_cmd,  // Line, timeout, rx, tx, modem, gpio.
    input  wire logic [2:0] pulse_cmd,  // Xoff, CTS, RTS requests.
    output var  uart_src_t  src
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] pulse_q;  // Last command, so a held request pulses once.

    // Levels follow the command one cycle late, as registered status does.
    // A long request would look like a stream of events, hence the edge.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            src     <= '0;
            pulse_q <= 3'h0;
        end else begin
            src.line_err     <= level_cmd[5];
            src.rx_timeout   <= level_cmd[4];
            src.rx_data      <= level_cmd[3];
            src.tx_below     <= level_cmd[2];
            // Dropped by the bench once the host reads the status.
            src.modem_change <= level_cmd[1];
            src.gpio_change  <= level_cmd[0];
            src.xoff_rcvd    <= pulse_cmd[2] & ~pulse_q[2];
            src.cts_deassert <= pulse_cmd[1] & ~pulse_q[1];
            src.rts_deassert <= pulse_cmd[0] & ~pulse_q[0];
            pulse_q          <= pulse_cmd;
        end
    end

endmodule // uart_event_model

`default_nettype wire

// >>> hdl/uart_irq_enable_ident.sv
/*
 * Interrupt enable, prioritised identification and enhanced feature
 * control for a single-channel UART.
 * Assumes a host bus front end that turns serial accesses into one-cycle
 * read and write strobes with a register select, and UART logic that
 * supplies the source conditions and the receive level synchronously.
 */
// Notes on behaviour
// - Enable bits 0-3: rx, tx, line, modem.
// - Bits 7,6,5 enable CTS, RTS, Xoff.
// - Enable bit 4 turns on sleep.
// - Bits 7:4 writable only with enhanced set.
// - Re-enabling transmit interrupt makes none anew.
// - Any enabled interrupt asserts the request.
// - Identification bits 7:6 mirror FIFO enable.
// - Bit 0 low means interrupt pending.
// - Best priority source is always reported.
// - Codes: line 06, timeout 0c, rx 04, tx 02.
// - Modem code 00, GPIO change code 30.
// - Xoff or special character code 10.
// - CTS/RTS deassert is lowest, code 20.
// - Auto CTS stops transmitter while CTS high.
// - Auto RTS: high at halt, low at resume.
// - Special character match flags identification.
// - Enhanced bit 4 write-enables protected fields.
// - Enhanced bits 3:0 pick software flow mode.
// - Thresholds are field value times four.
// - Modem status read clears its condition.
`default_nettype none

module uart_irq_enable_ident
    import uart_irq_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire reg_sel_t   reg_sel,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire uart_src_t  src,
    input  wire logic       fifo_enable,
    input  wire logic [6:0] rx_level,
    input  wire logic       rx_char_valid,
    input  wire logic [7:0] rx_char,
    input  wire logic [7:0] second_stop_char,
    input  wire logic [7:0] flow_threshold,
    input  wire logic       rts_force_active,
    input  wire logic       cts_pin_high,
    output logic            irq_n,
    output logic            tx_halt,
    output logic            rts_pin_high,
    output logic            sleep_enable,
    output logic            enhanced_we,
    output logic      [3:0] sw_flow_mode
);

    logic [7:0] enable_r;       // Interrupt enable register.
    logic [7:0] enhanced_r;     // Enhanced feature control register.
    logic       tx_below_d_r;   // Last cycle's transmit threshold level.
    logic       thr_flag_r;     // Transmit holding event, sticky.
    logic       xoff_flag_r;    // Xoff or special character, sticky.
    logic       cts_flag_r;     // CTS deassert event, sticky.
    logic       rts_flag_r;     // RTS deassert event, sticky.
    logic [7:0] rdata_r;        // Read data holding flop.
    logic       rvalid_r;       // Read answer strobe.
    logic       irq_n_r;        // Registered interrupt request, low active.
    logic       tx_halt_r;      // Transmitter stop request.
    logic       rts_high_r;     // Level of the RTS pin, high is inactive.

    logic       wr_enable;      // Write to the enable register.
    logic       wr_enhanced;    // Write to the enhanced register.
    logic       rd_ident;       // Read of the identification register.
    logic       special_hit;    // Received character matches.
    logic       p_line, p_tout, p_rx, p_tx, p_modem;
    logic       p_gpio, p_xoff, p_ctsrts;
    logic       any_pending;    // At least one enabled source pending.
    logic [5:0] ident_code;     // Identification bits 5:0.
    logic [6:0] halt_level;     // Halt threshold in characters.
    logic [6:0] resume_level;   // Resume threshold in characters.

    assign wr_enable   = reg_wr && (reg_sel == SEL_ENABLE);
    assign wr_enhanced = reg_wr && (reg_sel == SEL_ENHANCED);
    assign rd_ident    = reg_rd && (reg_sel == SEL_IDENT);

    // A source other than GPIO counts only while both its condition and enable are set.
    assign p_line   = src.line_err     && enable_r[EN_LINE];
    assign p_tout   = src.rx_timeout   && enable_r[EN_RX_DATA];
    assign p_rx     = src.rx_data      && enable_r[EN_RX_DATA];
    assign p_tx     = thr_flag_r       && enable_r[EN_TX_HOLD];
    // The modem condition is the upstream change flags, so reading the
    // modem status register clears it there and drops it here.
    assign p_modem  = src.modem_change && enable_r[EN_MODEM];
    // GPIO changes are already gated by the per-pin enables upstream.
    assign p_gpio   = src.gpio_change;
    assign p_xoff   = xoff_flag_r      && enable_r[EN_XOFF];
    assign p_ctsrts = (cts_flag_r && enable_r[EN_CTS])
                   || (rts_flag_r && enable_r[EN_RTS]);
    assign any_pending = p_line || p_tout || p_rx || p_tx || p_modem
                      || p_gpio || p_xoff || p_ctsrts;

    // Priority encoder, best level first; time-out beats plain data.
    always_comb begin
        if (p_line) begin
            ident_code = CODE_LINE;
        end else if (p_tout) begin
            ident_code = CODE_TIMEOUT;
        end else if (p_rx) begin
            ident_code = CODE_RX_DATA;
        end else if (p_tx) begin
            ident_code = CODE_TX_HOLD;
        end else if (p_modem) begin
            ident_code = CODE_MODEM;
        end else if (p_gpio) begin
            ident_code = CODE_GPIO;
        end else if (p_xoff) begin
            ident_code = CODE_XOFF;
        end else if (p_ctsrts) begin
            ident_code = CODE_CTS_RTS;
        end else begin
            ident_code = CODE_NONE;
        end
    end

    // Interrupt enable register; the upper nibble is write protected.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_r <= ENABLE_RESET;
        end else if (wr_enable) begin
            enable_r[3:0] <= reg_wdata[3:0];
            if (enhanced_r[ENH_WRITE_EN]) begin
                enable_r[7:4] <= reg_wdata[7:4];
            end
        end
    end

    // Enhanced feature control register, always writable.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            enhanced_r <= ENHANCED_RESET;
        end else if (wr_enhanced) begin
            enhanced_r <= reg_wdata;
        end
    end

    // The transmit event fires on the threshold crossing only, so that
    // turning its enable back on while already below does not re-arm it.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_below_d_r <= 1'b0;
            thr_flag_r   <= 1'b0;
        end else begin
            tx_below_d_r <= src.tx_below;
            if (src.tx_below && !tx_below_d_r) begin
                thr_flag_r <= 1'b1;
            end else if ((rd_ident && ident_code == CODE_TX_HOLD)
                         || !src.tx_below) begin
                thr_flag_r <= 1'b0;
            end
        end
    end

    assign special_hit = enhanced_r[ENH_SPECIAL] && rx_char_valid
                      && (rx_char == second_stop_char);

    // Sticky event flags; a new event in the clearing cycle wins.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            xoff_flag_r <= 1'b0;
            cts_flag_r  <= 1'b0;
            rts_flag_r  <= 1'b0;
        end else begin
            if (src.xoff_rcvd || special_hit) begin
                xoff_flag_r <= 1'b1;
            end else if (rd_ident && ident_code == CODE_XOFF) begin
                xoff_flag_r <= 1'b0;
            end
            if (src.cts_deassert) begin
                cts_flag_r <= 1'b1;
            end else if (rd_ident && ident_code == CODE_CTS_RTS) begin
                cts_flag_r <= 1'b0;
            end
            if (src.rts_deassert) begin
                rts_flag_r <= 1'b1;
            end else if (rd_ident && ident_code == CODE_CTS_RTS) begin
                rts_flag_r <= 1'b0;
            end
        end
    end

    // Read path: answer one cycle after the strobe from a flop.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                unique case (reg_sel)
                    SEL_ENABLE:   rdata_r <= enable_r;
                    SEL_IDENT:    rdata_r <= {{2{fifo_enable}},
                                              ident_code};
                    SEL_ENHANCED: rdata_r <= enhanced_r;
                    SEL_NONE:     rdata_r <= 8'h00;
                endcase
            end
        end
    end

    // Interrupt request follows the pending set one cycle later.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= !any_pending;
        end
    end

    // Auto CTS: stop the transmitter while the pin is high.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_halt_r <= 1'b0;
        end else begin
            tx_halt_r <= enhanced_r[ENH_AUTO_CTS] && cts_pin_high;
        end
    end

    assign halt_level   = {1'b0, flow_threshold[THR_HALT_LSB +: 4],
                           2'b00};
    assign resume_level = {1'b0, flow_threshold[THR_RESUME_LSB +: 4],
                           2'b00};

    // Auto RTS with hysteresis; without it, the modem control bit rules.
    // No check that halt exceeds resume; if not, halt wins each cycle.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rts_high_r <= 1'b1;
        end else if (enhanced_r[ENH_AUTO_RTS]) begin
            if (rx_level >= halt_level) begin
                rts_high_r <= 1'b1;
            end else if (rx_level <= resume_level) begin
                rts_high_r <= 1'b0;
            end
        end else begin
            rts_high_r <= !rts_force_active;
        end
    end

    assign reg_rdata    = rdata_r;
    assign reg_rvalid   = rvalid_r;
    assign irq_n        = irq_n_r;
    assign tx_halt      = tx_halt_r;
    assign rts_pin_high = rts_high_r;
    assign sleep_enable = enable_r[EN_SLEEP];
    assign enhanced_we  = enhanced_r[ENH_WRITE_EN];
    assign sw_flow_mode = enhanced_r[ENH_SW_FLOW_LSB +: 4];

    property p_protect_upper;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_enable && !enhanced_r[ENH_WRITE_EN]
            |=> $stable(enable_r[7:4]);
    endproperty
    a_protect_upper: assert property (p_protect_upper)
        else $error("Protected enable bits changed.");

    property p_lower_write;
        @(posedge sys_clk) disable iff (!reset_n)
        wr_enable |=> enable_r[3:0] == $past(reg_wdata[3:0]);
    endproperty
    a_lower_write: assert property (p_lower_write)
        else $error("Enable bits 3:0 did not take the write.");

    property p_irq_follow;
        @(posedge sys_clk) disable iff (!reset_n)
        any_pending |=> !irq_n;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("Interrupt request missing for a pending source.");

    property p_irq_release;
        @(posedge sys_clk) disable iff (!reset_n)
        !any_pending ##1 !any_pending |-> irq_n;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("Interrupt request held with nothing pending.");

    property p_ident_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        rd_ident && !any_pending
            |=> reg_rvalid && reg_rdata == {{2{$past(fifo_enable)}},
                                            CODE_NONE};
    endproperty
    a_ident_idle: assert property (p_ident_idle)
        else $error("Idle identification value wrong.");

    property p_line_first;
        @(posedge sys_clk) disable iff (!reset_n)
        rd_ident && p_line |=> reg_rdata[5:0] == CODE_LINE;
    endproperty
    a_line_first: assert property (p_line_first)
        else $error("Line status not reported first.");

    property p_tx_edge_only;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(thr_flag_r) |-> $past(src.tx_below) && !$past(tx_below_d_r);
    endproperty
    a_tx_edge_only: assert property (p_tx_edge_only)
        else $error("Transmit event set without a crossing.");

    property p_rts_halt;
        @(posedge sys_clk) disable iff (!reset_n)
        enhanced_r[ENH_AUTO_RTS] && rx_level >= halt_level
            |=> rts_pin_high;
    endproperty
    a_rts_halt: assert property (p_rts_halt)
        else $error("RTS not raised at the halt level.");

    property p_cts_halt;
        @(posedge sys_clk) disable iff (!reset_n)
        enhanced_r[ENH_AUTO_CTS] && cts_pin_high |=> tx_halt;
    endproperty
    a_cts_halt: assert property (p_cts_halt)
        else $error("Transmitter not stopped on high CTS.");

    property p_special;
        @(posedge sys_clk) disable iff (!reset_n)
        special_hit |=> xoff_flag_r ##1 1'b1;
    endproperty
    a_special: assert property (p_special)
        else $error("Special character match not flagged.");

endmodule : uart_irq_enable_ident

`default_nettype wire

// >>> hdl/uart_irq_pkg.sv
/*
 * Package for the UART interrupt enable, identification and enhanced
 * feature block: register selects, bit positions, reset values and the
 * identification codes.
 * Assumes the host bus front end decodes its own addresses into the
 * register select code declared here.
 */
`default_nettype none

package uart_irq_pkg;

    // Register select presented by the host bus front end.
    typedef enum logic [1:0] {
        SEL_ENABLE   = 2'b00,  // Interrupt enable register.
        SEL_IDENT    = 2'b01,  // Interrupt identification register.
        SEL_ENHANCED = 2'b10,  // Enhanced feature control register.
        SEL_NONE     = 2'b11   // Not served here; reads return zero.
    } reg_sel_t;

    // Event and condition sources from the rest of the UART.
    typedef struct packed {
        logic line_err;      // Receiver line status error, level.
        logic rx_timeout;    // Receiver time-out, level.
        logic rx_data;       // Receive data at trigger, level.
        logic tx_below;      // Transmit holding below threshold, level.
        logic modem_change;  // Modem status change flags, level.
        logic gpio_change;   // Enabled GPIO input change, level.
        logic xoff_rcvd;     // Xoff character received, pulse.
        logic cts_deassert;  // CTS went active to inactive, pulse.
        logic rts_deassert;  // RTS went active to inactive, pulse.
    } uart_src_t;

    // Reset values of the writable registers.
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] ENHANCED_RESET = 8'h00;

    // Interrupt enable bit positions.
    localparam int EN_RX_DATA  = 0;
    localparam int EN_TX_HOLD  = 1;
    localparam int EN_LINE     = 2;
    localparam int EN_MODEM    = 3;
    localparam int EN_SLEEP    = 4;
    localparam int EN_XOFF     = 5;
    localparam int EN_RTS      = 6;
    localparam int EN_CTS      = 7;

    // Enhanced feature control bit positions.
    localparam int ENH_SW_FLOW_LSB = 0;
    localparam int ENH_WRITE_EN    = 4;
    localparam int ENH_SPECIAL     = 5;
    localparam int ENH_AUTO_RTS    = 6;
    localparam int ENH_AUTO_CTS    = 7;

    // Threshold fields of the flow threshold register.
    localparam int THR_HALT_LSB   = 0;
    localparam int THR_RESUME_LSB = 4;
    localparam int THR_STEP_SHIFT = 2;  // Field times four.

    // Identification bits 5:0 for each source.
    localparam logic [5:0] CODE_LINE    = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
    localparam logic [5:0] CODE_RX_DATA = 6'h04;
    localparam logic [5:0] CODE_TX_HOLD = 6'h02;
    localparam logic [5:0] CODE_MODEM   = 6'h00;
    localparam logic [5:0] CODE_GPIO    = 6'h30;
    localparam logic [5:0] CODE_XOFF    = 6'h10;
    localparam logic [5:0] CODE_CTS_RTS = 6'h20;
    localparam logic [5:0] CODE_NONE    = 6'h01;

endpackage : uart_irq_pkg

`default_nettype wire
